//--- tb/ckswu_checker.sv
module ckswu_checker
   import ckswu_pkg::*;
#(parameter logic [15:0] OST_CYC = 16'd8) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic [2:0] multiplier_input_prescale,
   input wire logic [3:0] pll_in_divide,
   input wire logic [3:0] cpu_clock_divide,
   input wire logic [5:0] osc_power_en,
   input wire logic [2:0] clock_select,
   input wire logic [1:0] switch_monitor_config,
   input wire logic       switch_busy,
   input wire logic       new_clk_in,
   input wire logic       pll_lock_in
);
   typedef struct packed {logic [15:0] b; logic [7:0] e; logic n;} ckswu_hlp_s;
   ckswu_hlp_s      h_r, h_nxt;
   wire logic [2:0] mip = multiplier_input_prescale;
   wire logic [3:0] pexp = mip == 3'h7 ? 4'hc : mip == 3'h6 ? 4'h8 : {1'b0, mip} + 4'h1;
   // Busy cycles and new-clock rising edges seen during a switch
   always_comb begin
      h_nxt.b = switch_busy ? h_r.b + 16'h1 : 16'h0;
      h_nxt.e = switch_busy ? h_r.e + {7'h0, new_clk_in & ~h_r.n} : 8'h0;
      h_nxt.n = new_clk_in;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) h_r <= '0;
      else h_r <= h_nxt;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_pre; $stable(mip)[*4] |-> pll_in_divide == pexp; endproperty
   a_pre: assert property (p_pre) else $error("prescale factor wrong");
   property p_div; $onehot(cpu_clock_divide); endproperty
   a_div: assert property (p_div) else $error("cpu divider not 1,2,4,8");
   property p_pwr; osc_power_en[clock_select]; endproperty
   a_pwr: assert property (p_pwr) else $error("current source unpowered");
   property p_cfg; (switch_monitor_config != 2'h0)[*4] |-> !$rose(switch_busy); endproperty
   a_cfg: assert property (p_cfg) else $error("switch while disabled");
   property p_sw; $changed(clock_select) |-> $past(switch_busy) && h_r.e >= 8'd10; endproperty
   a_sw: assert property (p_sw) else $error("changeover too early");
   property p_lck;
      $changed(clock_select) && clock_select[0] && !clock_select[2] |-> $past(pll_lock_in, 3);
   endproperty
   a_lck: assert property (p_lck) else $error("multiplied source without lock");
   property p_ost;
      $changed(clock_select) && clock_select[1] && !$past(clock_select[1]) |-> h_r.b >= OST_CYC;
   endproperty
   a_ost: assert property (p_ost) else $error("start-up wait too short");
   property p_rdy; switch_busy |-> pready && !pslverr; endproperty
   a_rdy: assert property (p_rdy) else $error("bus stalled during switch");
   c_sw: cover property ($fell(switch_busy));
   c_pll: cover property (switch_busy && !pll_lock_in);
   c_cfg: cover property (switch_monitor_config != 2'h0);
endmodule

bind ckswu_ctrl ckswu_checker #(.OST_CYC(OST_CYC)) u_chk (.*);

//--- tb/tb.sv
`include "ckswu_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [11:0] OSC = `CKSWU_OFF_OSCCTL;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        usb_enable, pll_lock_in, new_clk_in, pll_clk_96, usb_clk_en, switch_busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  pstrb, pll_in_divide, cpu_clock_divide;
   logic [2:0]  multiplier_input_prescale, clock_select;
   logic [1:0]  switch_monitor_config;
   logic [5:0]  osc_power_en;
   logic        wdt_enable, osc_ready_in;
   logic [31:0] rv;
   int          miscompares = 0, check_count = 0, cyc = 0, seed, k;
   logic [3:0]  pd [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hc};
   logic [3:0]  cdv [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

   ckswu_ctrl #(.OST_CYC(16'd8)) i_dut (
      .pclk                      (pclk),
      .presetn                   (presetn),
      .psel                      (psel),
      .penable                   (penable),
      .pwrite                    (pwrite),
      .paddr                     (paddr),
      .pwdata                    (pwdata),
      .pstrb                     (pstrb),
      .prdata                    (prdata),
      .pready                    (pready),
      .pslverr                   (pslverr),
      .reset_source              (3'h0),
      .switch_monitor_config     (switch_monitor_config),
      .multiplier_input_prescale (multiplier_input_prescale),
      .usb_enable                (usb_enable),
      .wdt_enable                (wdt_enable),
      .pll_lock_in               (pll_lock_in),
      .osc_ready_in              (osc_ready_in),
      .new_clk_in                (new_clk_in),
      .pll_clk_96                (pll_clk_96),
      .osc_power_en              (osc_power_en),
      .clock_select              (clock_select),
      .pll_in_divide             (pll_in_divide),
      .cpu_clock_divide          (cpu_clock_divide),
      .usb_clk_en                (usb_clk_en),
      .switch_busy               (switch_busy)
   );

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      pll_clk_96 = 1'b0;
      forever #5.2 pll_clk_96 = ~pll_clk_96;
   end
   always @(posedge pclk) new_clk_in <= presetn & ~new_clk_in;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic done();
      repeat (4) @(posedge pclk);
      for (k = 0; switch_busy !== 1'b0 && k < 3000; k++) @(posedge pclk);
   endtask
   task automatic osc(input logic [2:0] c, input logic [2:0] n, input logic r);
      apb(1'b0, OSC, 32'h0, 4'h0);
      chk("osc_fields", {25'h0, c, n, r}, {25'h0, q[14:12], q[10:8], q[0]});
   endtask
   task automatic sw(input logic [2:0] s, input logic [7:0] k2, input logic w);
      apb(1'b1, OSC, {16'h0, `CKSWU_KEY_HI1, 8'h0}, 4'h2);
      apb(1'b1, OSC, {16'h0, `CKSWU_KEY_HI2, 8'h0}, 4'h2);
      apb(1'b1, OSC, {21'h0, s, 8'h0}, 4'h2);
      apb(1'b1, OSC, {24'h0, `CKSWU_KEY_LO1}, 4'h1);
      apb(1'b1, OSC, {24'h0, k2}, 4'h1);
      apb(1'b1, OSC, 32'h1, 4'h1);
      if (w) done();
   endtask

   initial begin
      seed = 32'h55aa;
      {presetn, psel, penable, pwrite, usb_enable, wdt_enable} = 6'h0;
      {paddr, pwdata, pstrb, switch_monitor_config} = '0;
      multiplier_input_prescale = 3'h0;
      pll_lock_in = 1'b1;
      osc_ready_in = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      osc(3'h0, 3'h0, 1'b0);
      chk("power_en", 32'h1, {26'h0, osc_power_en});
      sw(3'h0, `CKSWU_KEY_LO2, 1'b1);
      osc(3'h0, 3'h0, 1'b0);
      $display("test redundant done");
      osc_ready_in <= 1'b0;
      sw(3'h2, `CKSWU_KEY_LO2, 1'b0);
      repeat (30) @(posedge pclk);
      osc(3'h0, 3'h2, 1'b1);
      osc_ready_in <= 1'b1;
      done();
      osc(3'h2, 3'h2, 1'b0);
      chk("power_en", 32'h4, {26'h0, osc_power_en});
      pll_lock_in <= 1'b0;
      sw(3'h3, `CKSWU_KEY_LO2, 1'b0);
      repeat (100) @(posedge pclk);
      osc(3'h2, 3'h3, 1'b1);
      chk("lock_fail", 32'h0, {30'h0, q[5], q[3]});
      pll_lock_in <= 1'b1;
      done();
      osc(3'h3, 3'h3, 1'b0);
      usb_enable <= 1'b1;
      repeat (20) @(posedge pclk);
      k = 0;
      repeat (24) @(posedge pll_clk_96) #1 k += (usb_clk_en === 1'b1);
      chk("usb_half", 32'd12, k);
      $display("test switch done");
      @(posedge pclk);
      apb(1'b1, OSC, 32'h7800, 4'h2);
      apb(1'b1, OSC + 12'h4, 32'h0, 4'h1);
      apb(1'b1, OSC, 32'h9a00, 4'h2);
      apb(1'b1, OSC, 32'h0, 4'h2);
      osc(3'h3, 3'h3, 1'b0);
      sw(3'h0, 8'h56, 1'b1);
      osc(3'h3, 3'h0, 1'b0);
      usb_enable <= 1'b0;
      sw(3'h0, `CKSWU_KEY_LO2, 1'b1);
      osc(3'h0, 3'h0, 1'b0);
      wdt_enable <= 1'b1;
      sw(3'h5, `CKSWU_KEY_LO2, 1'b1);
      sw(3'h0, `CKSWU_KEY_LO2, 1'b1);
      chk("power_low_power_rc_osc", 32'h21, {26'h0, osc_power_en});
      switch_monitor_config <= 2'h2;
      sw(3'h2, `CKSWU_KEY_LO2, 1'b0);
      repeat (20) @(posedge pclk);
      apb(1'b0, OSC, 32'h0, 4'h0);
      chk("cur_nxt_req", 32'h0, {25'h0, q[14:12], q[10:8], q[0]});
      switch_monitor_config <= 2'h0;
      $display("test unlock done");
      for (int i = 0; i < 8; i++) begin
         rv = (i < 4) ? i : $random(seed);
         apb(1'b1, OSC + 12'h4, rv, 4'hf);
         chk("cpu_div", {28'h0, cdv[rv[1:0]]}, {28'h0, cpu_clock_divide});
         apb(1'b0, OSC + 12'h4, 32'h0, 4'h0);
         chk("clk_cfg", {30'h0, rv[1:0]}, q);
      end
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      chk("unmapped", 32'h0, q);
      for (int i = 0; i < 16; i++) begin
         multiplier_input_prescale <= (i < 8) ? 3'(i) : 3'($random(seed));
         repeat (4) @(posedge pclk);
         chk("pdiv", {28'h0, pd[multiplier_input_prescale]}, {28'h0, pll_in_divide});
      end
      $display("test prescale done");
      end_of_test();
   end
endmodule

//--- verilog/ckswu_ctrl.sv
`include "ckswu_map.svh"
module ckswu_ctrl
   import ckswu_pkg::*;
#(
   parameter logic [15:0] OST_CYC = `CKSWU_OST_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  reset_source,
   input  wire logic [1:0]  switch_monitor_config,
   input  wire logic [2:0]  multiplier_input_prescale,
   input  wire logic        usb_enable,
   input  wire logic        wdt_enable,
   input  wire logic        pll_lock_in,
   input  wire logic        osc_ready_in,
   input  wire logic        new_clk_in,
   input  wire logic        pll_clk_96,
   output logic      [5:0]  osc_power_en,
   output logic      [2:0]  clock_select,
   output logic      [3:0]  pll_in_divide,
   output logic      [3:0]  cpu_clock_divide,
   output logic             usb_clk_en,
   output logic             switch_busy
);
   ckswu_osc_s   osc_r, osc_nxt;
   ckswu_state_e st_r, st_nxt;
   ckswu_key_e   khi_r, khi_nxt, klo_r, klo_nxt;
   logic [1:0]   cpu_clock_divider_r, cpu_clock_divider_nxt;
   logic [15:0]  cnt_r, cnt_nxt;
   logic [5:0]   pwr_r, pwr_nxt;
   logic [2:0]   old_r, old_nxt;
   logic         strap_r, strap_nxt;
   logic [1:0]   lock_s_r, rdy_s_r, nclk_s_r;
   logic         nclk_d_r, usbdiv_r, usb_en_s_r, usb_en_s1_r;
   logic [2:0]   cfg_s1_r, cfg_s2_r;
   logic [1:0]   en1_r;
   logic         wr, rd, sw_on, is_pll, nclk_rise;
   logic [31:0]  rdata_nxt;
   logic [31:0]  prdata_r;

   assign wr     = psel & penable & pwrite;
   // Read data captured in setup, stands through access
   assign rd     = psel & ~penable & ~pwrite;
   assign sw_on  = (switch_monitor_config == `CKSWU_CFG_SWITCH_ON);
   assign is_pll = (osc_r.nxt == `CKSWU_SRC_FAST_RC_WITH_MULTIPLIER) | (osc_r.nxt == `CKSWU_SRC_PRIPLL);
   assign nclk_rise = nclk_s_r[1] & ~nclk_d_r;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = prdata_r;

   always_comb begin
      osc_nxt = osc_r;
      st_nxt  = st_r;
      khi_nxt = khi_r;
      klo_nxt = klo_r;
      cnt_nxt = cnt_r;
      pwr_nxt = pwr_r;
      old_nxt = old_r;
      strap_nxt = 1'b1;
      cpu_clock_divider_nxt = cpu_clock_divider_r;
      if (!strap_r) begin
         osc_nxt.cur = reset_source;
         osc_nxt.nxt = reset_source;
         pwr_nxt = 6'h01 << reset_source;
      end
      if (wr) begin
         khi_nxt = CKSWU_KEY_NONE;
         klo_nxt = CKSWU_KEY_NONE;
         if (paddr == `CKSWU_OFF_OSCCTL) begin
            if (pstrb[1]) begin
               if (khi_r == CKSWU_KEY_OPEN) begin
                  osc_nxt.nxt = pwdata[`CKSWU_NEXT_LSB +: 3];
               end else if (pwdata[15:8] == `CKSWU_KEY_HI1) begin
                  khi_nxt = CKSWU_KEY_ONE;
               end else if (khi_r == CKSWU_KEY_ONE && pwdata[15:8] == `CKSWU_KEY_HI2) begin
                  khi_nxt = CKSWU_KEY_OPEN;
               end
            end
            if (pstrb[0]) begin
               if (klo_r == CKSWU_KEY_OPEN) begin
                  osc_nxt.secondary_osc_keep = pwdata[`CKSWU_BIT_SECONDARY_OSC_EN];
                  if (pwdata[`CKSWU_BIT_REQ] && sw_on && st_r == CKSWU_IDLE) begin
                     osc_nxt.req = 1'b1;
                  end
               end else if (pwdata[7:0] == `CKSWU_KEY_LO1) begin
                  klo_nxt = CKSWU_KEY_ONE;
               end else if (klo_r == CKSWU_KEY_ONE && pwdata[7:0] == `CKSWU_KEY_LO2) begin
                  klo_nxt = CKSWU_KEY_OPEN;
               end
            end
         end else if (paddr == `CKSWU_OFF_CLKCFG && pstrb[0]) begin
            cpu_clock_divider_nxt = pwdata[1:0];
         end
      end
      unique case (st_r)
         CKSWU_IDLE: begin
            if (osc_r.req) begin
               if (osc_r.cur == osc_r.nxt) begin
                  osc_nxt.req = 1'b0;
               end else begin
                  osc_nxt.lock = 1'b0;
                  osc_nxt.fail = 1'b0;
                  old_nxt = osc_r.cur;
                  pwr_nxt[osc_r.nxt] = 1'b1;
                  cnt_nxt = OST_CYC;
                  st_nxt = (osc_r.nxt == `CKSWU_SRC_PRI || osc_r.nxt == `CKSWU_SRC_PRIPLL)
                           ? CKSWU_OST : CKSWU_START;
               end
            end
         end
         CKSWU_START: st_nxt = is_pll ? CKSWU_LOCKW : CKSWU_SETTLE;
         CKSWU_OST: begin
            if (cnt_r != 16'h0000) begin
               cnt_nxt = cnt_r - 16'h0001;
            end else if (rdy_s_r[1]) begin
               st_nxt = is_pll ? CKSWU_LOCKW : CKSWU_SETTLE;
            end
         end
         CKSWU_LOCKW: begin
            if (lock_s_r[1]) begin
               osc_nxt.lock = 1'b1;
               st_nxt = CKSWU_SETTLE;
            end
         end
         CKSWU_SETTLE: begin
            if (st_r != st_nxt) begin
               cnt_nxt = 16'h0000;
            end
         end
      endcase
      if (st_r != CKSWU_SETTLE && st_nxt == CKSWU_SETTLE) begin
         cnt_nxt = {12'h000, `CKSWU_SETTLE_CYC};
      end
      if (st_r == CKSWU_SETTLE && nclk_rise) begin
         if (cnt_r == 16'h0001) begin
            osc_nxt.cur = osc_r.nxt;
            osc_nxt.req = 1'b0;
            st_nxt = CKSWU_IDLE;
            pwr_nxt[old_r] = 1'b0;
            if (old_r == `CKSWU_SRC_LOW_POWER_RC_OSC && wdt_enable) begin
               pwr_nxt[old_r] = 1'b1;
            end
            if (old_r == `CKSWU_SRC_SEC && osc_r.secondary_osc_keep) begin
               pwr_nxt[old_r] = 1'b1;
            end
            if (old_r == `CKSWU_SRC_FAST_RC_WITH_MULTIPLIER && osc_r.nxt == `CKSWU_SRC_FRC) begin
               pwr_nxt[`CKSWU_SRC_FRC] = 1'b1;
            end
         end
         cnt_nxt = cnt_r - 16'h0001;
      end
      if (!sw_on) begin
         osc_nxt.req = 1'b0;
         osc_nxt.nxt = osc_r.cur;
      end
      if (osc_r.lock && !lock_s_r[1] && is_pll && st_r == CKSWU_IDLE) begin
         osc_nxt.fail = 1'b1;
      end
      rdata_nxt = prdata_r;
      if (rd) begin
         unique case (paddr)
            `CKSWU_OFF_OSCCTL: rdata_nxt = {16'h0000, 1'b0, osc_r.cur, 1'b0, osc_r.nxt,
                                            2'b00, osc_r.lock, 1'b0, osc_r.fail, 1'b0,
                                            osc_r.secondary_osc_keep, osc_r.req};
            `CKSWU_OFF_CLKCFG: rdata_nxt = {30'h0, cpu_clock_divider_r};
            `CKSWU_OFF_STATUS: rdata_nxt = {23'h0, st_r, cfg_s2_r,
                                            usb_en_s_r, switch_busy, lock_s_r[1]};
            default:           rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_r <= '0;
         st_r <= CKSWU_IDLE;
         khi_r <= CKSWU_KEY_NONE;
         klo_r <= CKSWU_KEY_NONE;
         cnt_r <= 16'h0000;
         pwr_r <= 6'h01;
         old_r <= 3'h0;
         strap_r <= 1'b0;
         cpu_clock_divider_r <= 2'h0;
         prdata_r <= 32'h0000_0000;
      end else begin
         osc_r <= osc_nxt;
         st_r <= st_nxt;
         khi_r <= khi_nxt;
         klo_r <= klo_nxt;
         cnt_r <= cnt_nxt;
         pwr_r <= pwr_nxt;
         old_r <= old_nxt;
         strap_r <= strap_nxt;
         cpu_clock_divider_r <= cpu_clock_divider_nxt;
         prdata_r <= rdata_nxt;
      end
   end

   // Synchronisers for analog and foreign-clock inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_s_r <= 2'b00;
         rdy_s_r <= 2'b00;
         nclk_s_r <= 2'b00;
         nclk_d_r <= 1'b0;
         cfg_s1_r <= 3'h0;
         cfg_s2_r <= 3'h0;
         usb_en_s1_r <= 1'b0;
         usb_en_s_r <= 1'b0;
      end else begin
         lock_s_r <= {lock_s_r[0], pll_lock_in};
         rdy_s_r <= {rdy_s_r[0], osc_ready_in};
         nclk_s_r <= {nclk_s_r[0], new_clk_in};
         nclk_d_r <= nclk_s_r[1];
         cfg_s1_r <= multiplier_input_prescale;
         cfg_s2_r <= cfg_s1_r;
         usb_en_s1_r <= usb_enable;
         usb_en_s_r <= usb_en_s1_r;
      end
   end

   // USB branch: 96 MHz halved to 48 MHz enable
   always_ff @(posedge pll_clk_96 or negedge presetn) begin
      if (!presetn) begin
         usbdiv_r <= 1'b0;
         en1_r <= 2'b00;
      end else begin
         en1_r <= {en1_r[0], usb_enable};
         usbdiv_r <= ~usbdiv_r;
      end
   end

   always_comb begin
      unique case (cfg_s2_r)
         3'h6:    pll_in_divide = 4'd8;
         3'h7:    pll_in_divide = 4'd12;
         default: pll_in_divide = {1'b0, cfg_s2_r} + 4'd1;
      endcase
      cpu_clock_divide = 4'h1 << cpu_clock_divider_r;
   end

   // USB clock only from primary multiplier source
   assign usb_clk_en   = en1_r[1] & usbdiv_r
                         & (osc_r.cur == `CKSWU_SRC_PRIPLL);
   assign osc_power_en = pwr_r;
   assign clock_select = osc_r.cur;
   assign switch_busy  = (st_r != CKSWU_IDLE);
endmodule

//--- verilog/ckswu_map.svh
`ifndef CKSWU_MAP_SVH
`define CKSWU_MAP_SVH
`define CKSWU_OFF_OSCCTL   12'h000
`define CKSWU_OFF_CLKCFG   12'h004
`define CKSWU_OFF_STATUS   12'h008
`define CKSWU_KEY_HI1      8'h78
`define CKSWU_KEY_HI2      8'h9a
`define CKSWU_KEY_LO1      8'h46
`define CKSWU_KEY_LO2      8'h57
`define CKSWU_BIT_REQ      0
`define CKSWU_BIT_SECONDARY_OSC_EN  1
`define CKSWU_BIT_FAIL     3
`define CKSWU_BIT_LOCK     5
`define CKSWU_NEXT_LSB     8
`define CKSWU_CUR_LSB      12
`define CKSWU_SETTLE_CYC   4'd10
`define CKSWU_OST_CYC      16'd1024
`define CKSWU_SRC_FRC      3'h0
`define CKSWU_SRC_FAST_RC_WITH_MULTIPLIER   3'h1
`define CKSWU_SRC_PRI      3'h2
`define CKSWU_SRC_PRIPLL   3'h3
`define CKSWU_SRC_SEC      3'h4
`define CKSWU_SRC_LOW_POWER_RC_OSC     3'h5
`define CKSWU_CFG_SWITCH_ON 2'h0
`endif

//--- verilog/ckswu_pkg.sv
package ckswu_pkg;
   typedef enum logic [2:0] {CKSWU_IDLE, CKSWU_START, CKSWU_OST, CKSWU_LOCKW,
                             CKSWU_SETTLE} ckswu_state_e;
   typedef enum logic [1:0] {CKSWU_KEY_NONE, CKSWU_KEY_ONE, CKSWU_KEY_OPEN} ckswu_key_e;
   typedef struct packed {
      logic [2:0] cur;
      logic [2:0] nxt;
      logic       lock;
      logic       fail;
      logic       secondary_osc_keep;
      logic       req;
   } ckswu_osc_s;
endpackage
